/* File: src/bstap_pkg.sv */
// Package for the boundary-scan test access block: codes, sizes, cell layout, states
package bstap_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int IR_W      = 4;
	localparam int ID_W      = 32;
	localparam int OUT_CELLS = 58;
	localparam int IN_CELLS  = 4;
	localparam int BSR_LEN   = OUT_CELLS + IN_CELLS;

	// ************************************************************
	// Instruction codes
	// ************************************************************
	localparam logic [IR_W-1:0] IR_EXTERNAL_INTERCONNECT_TEST = 4'h0;
	localparam logic [IR_W-1:0] IR_IDENT                      = 4'h1;
	localparam logic [IR_W-1:0] IR_INTERNAL_TEST              = 4'h3;
	localparam logic [IR_W-1:0] IR_BYPASS                     = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE_VAL                = 4'h1;

	// ************************************************************
	// Reset, capture and drive values
	// ************************************************************
	localparam logic            BYPASS_CAPTURE_VAL = 1'h0;
	localparam logic            TDO_IDLE_VAL       = 1'h0;
	localparam logic            OE_N_OFF           = 1'h1;
	localparam logic            SDA_DRIVE_VAL      = 1'h0;
	localparam logic            SDA_RELEASED       = 1'h1;

	// ************************************************************
	// Mode bits passed to the system clock side
	// ************************************************************
	localparam int MODE_W         = 2;
	localparam int MODE_PINS_BIT  = 0;
	localparam int MODE_CORE_BIT  = 1;

	// ************************************************************
	// Tap controller states
	// ************************************************************
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} bstap_state_t;

	// ************************************************************
	// Output cells; last member is bit 0, which is cell 1 and leaves first
	// ************************************************************
	typedef struct packed {
		logic [3:0]  data_qualifier;           // Cells 55-58
		logic [7:0]  output_data;              // Cells 47-54
		logic [7:0]  sub_address_bus;          // Cells 39-46
		logic        output_data_strobe;       // Cell 38 [RULE_18]
		logic [11:0] counter_bus;              // Cells 26-37 [RULE_17]
		logic        bunch_count_strobe;       // Cell 25
		logic        event_count_low_strobe;   // Cell 24
		logic        event_count_high_strobe;  // Cell 23
		logic        trigger_accept;           // Cell 22 [RULE_16]
		logic [7:2]  broadcast_bus;            // Cells 16-21 [RULE_15]
		logic        event_count_reset;        // Cell 15
		logic        bunch_count_reset;        // Cell 14
		logic        user_broadcast_strobe;    // Cell 13
		logic        system_broadcast_strobe;  // Cell 12 [RULE_14]
		logic        clock_with_trigger;       // Cell 11
		logic        deskewed_clock_2;         // Cell 10
		logic        deskewed_clock_1;         // Cell 9
		logic        recovered_clock;          // Cell 8 [RULE_13]
		logic        double_error_strobe;      // Cell 7
		logic        single_error_strobe;      // Cell 6
		logic        serial_secondary_channel; // Cell 5
		logic        prom_chip_enable_reset;   // Cell 4
		logic        prom_serial_clock;        // Cell 3
		logic        i2c_data_out;             // Cell 2
		logic        link_ready_out;           // Cell 1
	} bstap_outs_t;

	// ************************************************************
	// Input cells
	// ************************************************************
	typedef struct packed {
		logic sda_in;             // Cell 62
		logic scl_in;             // Cell 61
		logic prom_serial_input;  // Cell 60
		logic general_reset;      // Cell 59
	} bstap_ins_t;

endpackage

/* File: src/bstap_sync_if.sv */
// Interface carrying one signal group into a two-flop synchroniser
`timescale 1ns/100ps
`default_nettype none

interface bstap_sync_if #(parameter int W = 1);
	logic [W-1:0] d;
	logic [W-1:0] q;
	modport sync (input d, output q);
	modport user (output d, input q);
endinterface // bstap_sync_if

`default_nettype wire

/* File: src/bstap_sync.sv */
// Two-flop synchroniser for a level or a toggle
`timescale 1ns/100ps
`default_nettype none

module bstap_sync #(parameter int W = 1) (
	input wire logic   clk,   // Destination clock
	input wire logic   nrst,  // Synchronous reset, active low
	bstap_sync_if.sync p      // Source value in, synchronised value out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_q;

	// The first stage feeds only the second stage
	always_comb begin
		nxt_meta = p.d;
		nxt_q    = meta_ff;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= nxt_meta;
			q_ff    <= nxt_q;
		end
	end

	assign p.q = q_ff;
endmodule // bstap_sync

`default_nettype wire

/* File: src/bstap_top.sv */
// Boundary-scan test access port with 62-cell boundary register
//
// Contract
// RULE_01: Provide boundary-scan port for interconnect testing.
// RULE_02: Identification register shifts out its fixed code.
// RULE_03: Instruction register is exactly four bits.
// RULE_04: Code 0000 drives pins, captures pin inputs.
// RULE_05: Code 0001 scans out identification register.
// RULE_06: Code 0011 stimulates core, captures its responses.
// RULE_07: Code 1111 puts one-bit bypass in path.
// RULE_08: Instruction scan always captures and shifts 0001.
// RULE_09: Cells for every digital pin, none analogue.
// RULE_10: Cells also for internal custom/standard-cell signals.
// RULE_11: Cells 1-4 and 59-62 fixed order.
// RULE_12: Cells 5-7: secondary channel, error strobes.
// RULE_13: Cells 8-11: recovered, deskewed, trigger clocks.
// RULE_14: Cells 12-15: broadcast strobes, counter resets.
// RULE_15: Cells 16-21: broadcast bits 2 to 7.
// RULE_16: Cells 22-25: trigger and counter strobes.
// RULE_17: Cells 26-37: counter bus, LSB first.
// RULE_18: Cells 38-58: strobe, subaddress, data, qualifier.
// RULE_19: Undefined codes behave as bypass.
// RULE_20: Standard sixteen-state controller; test reset selects ident.
`timescale 1ns/100ps
`default_nettype none

module bstap_top #(
	parameter logic [31:0] ID_VALUE = 32'h0ABC_D001  // Arbitrary identification value
) (
	input  wire logic                   clk,       // System clock, 10 MHz
	input  wire logic                   nrst,      // System reset, sync, active low
	input  wire logic                   tck,       // Test clock from the tester
	input  wire logic                   ntrst,     // Test reset, sync to tck, active low
	input  wire logic                   tms,       // Test mode select
	input  wire logic                   tdi,       // Test data in
	output var  logic                   tdo,       // Test data out, falling tck
	output var  logic                   tdo_oe_n,  // Low while tdo is driven
	input  wire bstap_pkg::bstap_outs_t core_out,  // Functional outputs from the core
	output var  bstap_pkg::bstap_outs_t pin_out,   // Values towards the output pins
	input  wire bstap_pkg::bstap_ins_t  pin_in,    // Input pins, asynchronous
	output var  bstap_pkg::bstap_ins_t  core_in,   // Input values towards the core
	output var  logic                   sda_out,   // Open-drain data level, always low
	output var  logic                   sda_oe_n   // Low while data pin is pulled low
);
	import bstap_pkg::*;

	// ************************************************************
	// Test clock domain state
	// ************************************************************
	bstap_state_t          state_ff;
	logic [IR_W-1:0]       ir_ff;
	logic [IR_W-1:0]       ir_sh_ff;
	logic [ID_W-1:0]       id_sh_ff;
	logic                  byp_ff;
	logic [BSR_LEN-1:0]    bsr_sh_ff;
	logic [BSR_LEN-1:0]    bsr_upd_ff;
	logic [BSR_LEN-1:0]    held_ff;
	logic                  upd_tgl_ff;
	logic                  ack_tgl_ff;
	logic                  tdo_ff;
	logic                  tdo_oe_n_ff;

	bstap_state_t          nxt_state;
	logic [IR_W-1:0]       nxt_ir;
	logic [IR_W-1:0]       nxt_ir_sh;
	logic [ID_W-1:0]       nxt_id_sh;
	logic                  nxt_byp;
	logic [BSR_LEN-1:0]    nxt_bsr_sh;
	logic [BSR_LEN-1:0]    nxt_bsr_upd;
	logic [BSR_LEN-1:0]    nxt_held;
	logic                  nxt_upd_tgl;
	logic                  nxt_ack_tgl;
	logic                  nxt_tdo;
	logic                  nxt_tdo_oe_n;

	logic                  sel_bsr;
	logic                  sel_id;
	logic [MODE_W-1:0]     mode_tck;

	// ************************************************************
	// System clock domain state
	// ************************************************************
	logic [BSR_LEN-1:0]    snap_ff;
	logic                  snap_tgl_ff;
	logic [BSR_LEN-1:0]    upd_hold_ff;
	logic                  upd_seen_ff;
	bstap_outs_t           pin_out_ff;
	bstap_ins_t            core_in_ff;
	logic                  sda_oe_n_ff;

	logic [BSR_LEN-1:0]    nxt_snap;
	logic                  nxt_snap_tgl;
	logic [BSR_LEN-1:0]    nxt_upd_hold;
	logic                  nxt_upd_seen;
	bstap_outs_t           nxt_pin_out;
	bstap_ins_t            nxt_core_in;
	logic                  nxt_sda_oe_n;

	// ************************************************************
	// Crossings
	// ************************************************************
	bstap_sync_if #(.W(MODE_W))   mode_x ();
	bstap_sync_if #(.W(1))        upd_x ();
	bstap_sync_if #(.W(1))        ack_x ();
	bstap_sync_if #(.W(1))        snap_x ();
	bstap_sync_if #(.W(IN_CELLS)) pin_x ();

	assign mode_x.d = mode_tck;
	assign upd_x.d  = upd_tgl_ff;
	assign ack_x.d  = ack_tgl_ff;
	assign snap_x.d = snap_tgl_ff;
	assign pin_x.d  = pin_in;

	bstap_sync #(.W(MODE_W))   u_mode_sync (.clk(clk), .nrst(nrst), .p(mode_x));
	bstap_sync #(.W(1))        u_upd_sync  (.clk(clk), .nrst(nrst), .p(upd_x));
	bstap_sync #(.W(1))        u_ack_sync  (.clk(clk), .nrst(nrst), .p(ack_x));
	bstap_sync #(.W(IN_CELLS)) u_pin_sync  (.clk(clk), .nrst(nrst), .p(pin_x));
	bstap_sync #(.W(1))        u_snap_sync (.clk(tck), .nrst(ntrst), .p(snap_x));

	// ************************************************************
	// Instruction decode
	// ************************************************************
	always_comb begin
		sel_bsr  = (ir_ff == IR_EXTERNAL_INTERCONNECT_TEST) || (ir_ff == IR_INTERNAL_TEST); // [RULE_04] [RULE_06]
		sel_id   = (ir_ff == IR_IDENT); // [RULE_05]
		mode_tck = '0;
		mode_tck[MODE_PINS_BIT] = sel_bsr; // [RULE_04]
		mode_tck[MODE_CORE_BIT] = (ir_ff == IR_INTERNAL_TEST); // [RULE_06]
	end

	// ************************************************************
	// Tap controller and scan registers
	// ************************************************************
	always_comb begin
		nxt_state   = state_ff;
		nxt_ir      = ir_ff;
		nxt_ir_sh   = ir_sh_ff;
		nxt_id_sh   = id_sh_ff;
		nxt_byp     = byp_ff;
		nxt_bsr_sh  = bsr_sh_ff;
		nxt_bsr_upd = bsr_upd_ff;
		nxt_held    = held_ff;
		nxt_upd_tgl = upd_tgl_ff;
		nxt_ack_tgl = ack_tgl_ff;

		case (state_ff) // [RULE_20]
			ST_RESET:  nxt_state = tms ? ST_RESET  : ST_IDLE;
			ST_IDLE:   nxt_state = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: nxt_state = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: nxt_state = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: nxt_state = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: nxt_state = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: nxt_state = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: nxt_state = tms ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: nxt_state = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: nxt_state = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: nxt_state = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: nxt_state = tms ? ST_SEL_DR : ST_IDLE;
			default:   nxt_state = ST_RESET;
		endcase

		case (state_ff)
			ST_RESET: begin
				nxt_ir = IR_IDENT; // [RULE_20]
			end
			ST_CAP_IR: begin
				nxt_ir_sh = IR_CAPTURE_VAL; // [RULE_08]
			end
			ST_SH_IR: begin
				nxt_ir_sh = {tdi, ir_sh_ff[IR_W-1:1]}; // [RULE_03]
			end
			ST_UPD_IR: begin
				nxt_ir = ir_sh_ff; // [RULE_03]
			end
			ST_CAP_DR: begin
				nxt_id_sh  = ID_VALUE; // [RULE_02]
				nxt_byp    = BYPASS_CAPTURE_VAL; // [RULE_07]
				nxt_bsr_sh = held_ff; // [RULE_04] [RULE_06]
			end
			ST_SH_DR: begin
				if (sel_bsr) begin
					nxt_bsr_sh = {tdi, bsr_sh_ff[BSR_LEN-1:1]}; // [RULE_01]
				end else if (sel_id) begin
					nxt_id_sh = {tdi, id_sh_ff[ID_W-1:1]}; // [RULE_05]
				end else begin
					nxt_byp = tdi; // [RULE_07] [RULE_19]
				end
			end
			ST_UPD_DR: begin
				if (sel_bsr) begin
					nxt_bsr_upd = bsr_sh_ff; // [RULE_04] [RULE_06]
					nxt_upd_tgl = ~upd_tgl_ff;
				end
			end
			default: begin
				nxt_ir = ir_ff;
			end
		endcase

		// Take a fresh snapshot only while the system side holds it still
		if (snap_x.q != ack_tgl_ff) begin
			nxt_held    = snap_ff;
			nxt_ack_tgl = snap_x.q;
		end
	end

	always_ff @(posedge tck) begin
		if (!ntrst) begin
			state_ff   <= ST_RESET; // [RULE_20]
			ir_ff      <= IR_IDENT; // [RULE_20]
			ir_sh_ff   <= IR_CAPTURE_VAL;
			id_sh_ff   <= '0;
			byp_ff     <= BYPASS_CAPTURE_VAL;
			bsr_sh_ff  <= '0;
			bsr_upd_ff <= '0;
			held_ff    <= '0;
			upd_tgl_ff <= 1'h0;
			ack_tgl_ff <= 1'h0;
		end else begin
			state_ff   <= nxt_state;
			ir_ff      <= nxt_ir;
			ir_sh_ff   <= nxt_ir_sh;
			id_sh_ff   <= nxt_id_sh;
			byp_ff     <= nxt_byp;
			bsr_sh_ff  <= nxt_bsr_sh;
			bsr_upd_ff <= nxt_bsr_upd;
			held_ff    <= nxt_held;
			upd_tgl_ff <= nxt_upd_tgl;
			ack_tgl_ff <= nxt_ack_tgl;
		end
	end

	// ************************************************************
	// Test data out, changed on the falling edge so the tester samples it cleanly
	// ************************************************************
	always_comb begin
		nxt_tdo      = TDO_IDLE_VAL;
		nxt_tdo_oe_n = OE_N_OFF;
		if (state_ff == ST_SH_IR) begin
			nxt_tdo      = ir_sh_ff[0]; // [RULE_08]
			nxt_tdo_oe_n = 1'h0;
		end else if (state_ff == ST_SH_DR) begin
			nxt_tdo_oe_n = 1'h0;
			if (sel_bsr) begin
				nxt_tdo = bsr_sh_ff[0]; // [RULE_11]
			end else if (sel_id) begin
				nxt_tdo = id_sh_ff[0]; // [RULE_02]
			end else begin
				nxt_tdo = byp_ff; // [RULE_19]
			end
		end
	end

	always_ff @(negedge tck) begin
		if (!ntrst) begin
			tdo_ff      <= TDO_IDLE_VAL;
			tdo_oe_n_ff <= OE_N_OFF;
		end else begin
			tdo_ff      <= nxt_tdo;
			tdo_oe_n_ff <= nxt_tdo_oe_n;
		end
	end

	// ************************************************************
	// System side: snapshot, update hand-off and pin muxing
	// ************************************************************
	always_comb begin
		nxt_snap     = snap_ff;
		nxt_snap_tgl = snap_tgl_ff;
		nxt_upd_hold = upd_hold_ff;
		nxt_upd_seen = upd_seen_ff;

		// Inputs in the top cells, core outputs below them in cell order
		if (ack_x.q == snap_tgl_ff) begin
			nxt_snap     = {pin_x.q, core_out}; // [RULE_09] [RULE_10] [RULE_11]
			nxt_snap_tgl = ~snap_tgl_ff;
		end

		// The update word is static for at least four tck cycles after the toggle
		if (upd_x.q != upd_seen_ff) begin
			nxt_upd_hold = bsr_upd_ff;
			nxt_upd_seen = upd_x.q;
		end

		if (mode_x.q[MODE_PINS_BIT]) begin
			nxt_pin_out = bstap_outs_t'(upd_hold_ff[OUT_CELLS-1:0]); // [RULE_04] [RULE_12]
		end else begin
			nxt_pin_out = core_out;
		end

		// Both bits needed: a half-synchronised mode change never frees the core side alone
		if (mode_x.q[MODE_CORE_BIT] && mode_x.q[MODE_PINS_BIT]) begin
			nxt_core_in = bstap_ins_t'(upd_hold_ff[BSR_LEN-1:OUT_CELLS]); // [RULE_06] [RULE_11]
		end else begin
			nxt_core_in = pin_x.q;
		end

		// Open-drain data pin: enable low pulls the line low, high releases it
		nxt_sda_oe_n = nxt_pin_out.i2c_data_out; // [RULE_11]
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			snap_ff     <= '0;
			snap_tgl_ff <= 1'h0;
			upd_hold_ff <= '0;
			upd_seen_ff <= 1'h0;
			pin_out_ff  <= '0;
			core_in_ff  <= '0;
			sda_oe_n_ff <= SDA_RELEASED;
		end else begin
			snap_ff     <= nxt_snap;
			snap_tgl_ff <= nxt_snap_tgl;
			upd_hold_ff <= nxt_upd_hold;
			upd_seen_ff <= nxt_upd_seen;
			pin_out_ff  <= nxt_pin_out;
			core_in_ff  <= nxt_core_in;
			sda_oe_n_ff <= nxt_sda_oe_n;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign tdo      = tdo_ff;
	assign tdo_oe_n = tdo_oe_n_ff;
	assign pin_out  = pin_out_ff;
	assign core_in  = core_in_ff;
	assign sda_out  = SDA_DRIVE_VAL;
	assign sda_oe_n = sda_oe_n_ff;

endmodule // bstap_top

`default_nettype wire

/* File: tb/bstap_props.sv */
// Concurrent checks on the ports of the boundary-scan test access block
`timescale 1ns/100ps
`default_nettype none

module bstap_props
	import bstap_pkg::*;
#(
	parameter logic [31:0] ID_VALUE = 32'h0ABC_D001  // Arbitrary identification value
) (
	input wire logic        clk,       // System clock
	input wire logic        nrst,      // System reset, active low
	input wire logic        tck,       // Test clock
	input wire logic        ntrst,     // Test reset, active low
	input wire logic        tms,       // Mode select
	input wire logic        tdo,       // Data out
	input wire logic        tdo_oe_n,  // Low while data out is driven
	input wire bstap_outs_t pin_out,   // Output pin values
	input wire logic        sda_out,   // Open-drain level
	input wire logic        sda_oe_n   // Open-drain enable, active low
);
	// ************************************************************
	// Entry paths that start from a known controller state
	// ************************************************************
	sequence s_from_reset;
		tms [*5] ##1 !tms;
	endsequence
	sequence s_to_shift_ir;
		s_from_reset ##1 tms [*2] ##1 !tms [*2];
	endsequence
	sequence s_to_shift_dr;
		s_from_reset ##1 tms ##1 !tms [*2];
	endsequence

	a_ir_capture_val: assert property (@(posedge tck) disable iff (!ntrst)
		s_to_shift_ir |=> (!tdo_oe_n && tdo) ##1 !tdo [*3])
		else $error("instruction capture is not 0001");
	a_id_first_bit: assert property (@(posedge tck) disable iff (!ntrst)
		s_to_shift_dr |=> !tdo_oe_n && (tdo == ID_VALUE[0]))
		else $error("identification bit 0 not shifted first after reset");
	a_id_second_bit: assert property (@(posedge tck) disable iff (!ntrst)
		s_to_shift_dr ##1 !tms |=> tdo == ID_VALUE[1])
		else $error("identification bit 1 wrong");
	a_tms_ends_shift: assert property (@(posedge tck) disable iff (!ntrst)
		tms |=> tdo_oe_n)
		else $error("data out still driven after tms high");
	a_shift_holds_on: assert property (@(posedge tck) disable iff (!ntrst)
		!tdo_oe_n && !tms |=> !tdo_oe_n)
		else $error("shift left with tms low");
	a_idle_out_low: assert property (@(posedge tck) disable iff (!ntrst)
		tdo_oe_n |-> !tdo)
		else $error("data out not low while undriven");
	a_sda_level_low: assert property (@(posedge clk) disable iff (!nrst)
		!sda_out)
		else $error("open-drain level not low");
	a_sda_follows_cell: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst) |-> sda_oe_n == pin_out.i2c_data_out)
		else $error("data pin enable differs from cell 2");
endmodule // bstap_props

bind bstap_top bstap_props #(.ID_VALUE(ID_VALUE)) u_props (
	.clk(clk),
	.nrst(nrst),
	.tck(tck),
	.ntrst(ntrst),
	.tms(tms),
	.tdo(tdo),
	.tdo_oe_n(tdo_oe_n),
	.pin_out(pin_out),
	.sda_out(sda_out),
	.sda_oe_n(sda_oe_n)
);

`default_nettype wire

/* File: tb/bstap_tester.sv */
// Behavioural boundary-scan tester driving the test port
`timescale 1ns/100ps
`default_nettype none

module bstap_tester (
	output var  logic tck,      // Test clock, still between frames
	output var  logic ntrst,    // Test reset, active low
	output var  logic tms,      // Mode select
	output var  logic tdi,      // Data in
	input  wire logic tdo,      // Data out from the device
	input  wire logic tdo_oe_n  // Low while the device drives data out
);
	initial begin
		tck = 1'b0;
		ntrst = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// Inputs change while tck is low; data out is taken on the rise
	task automatic tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#62.5 tck = 1'b1;
		// An undriven data out reads as unknown so a comparison cannot pass on it
		o = tdo_oe_n ? 1'bx : tdo;
		#62.5 tck = 1'b0;
	endtask

	task automatic reset_port();
		logic o;
		ntrst = 1'b0;
		repeat (3) tick(1'b1, 1'b0, o);
		ntrst = 1'b1;
	endtask

	// Data in toggles outside shifts so a stale level is never mistaken for data
	task automatic scan(input logic ir, input logic pre, input int n,
			input logic [63:0] din, output logic [63:0] dout);
		logic o;
		dout = '0;
		if (pre) begin
			repeat (5) tick(1'b1, ~tdi, o);
			tick(1'b0, ~tdi, o);
		end
		tick(1'b1, ~tdi, o);
		if (ir) begin
			tick(1'b1, ~tdi, o);
		end
		tick(1'b0, ~tdi, o);
		tick(1'b0, ~tdi, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, ~tdi, o);
		tick(1'b0, ~tdi, o);
	endtask
endmodule // bstap_tester

`default_nettype wire

/* File: tb/boundary_scan_tap_tb_top.sv */
// Self-checking testbench for the boundary-scan test access block
`timescale 1ns/100ps
`default_nettype none

module boundary_scan_tap_tb_top;
	import bstap_pkg::*;
	localparam logic [31:0] TB_ID = 32'h5A3C_96E1;  // Arbitrary identification value
	localparam logic [63:0] PAT_A = 64'h2A5C_3F09_E17B_64D5;
	localparam logic [63:0] PAT_B = 64'h15A3_C0F6_1E84_9B2A;

	logic        clk;
	logic        nrst;
	logic        tck;
	logic        ntrst;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic        tdo_oe_n;
	bstap_outs_t core_out;
	bstap_outs_t pin_out;
	bstap_ins_t  pin_in;
	bstap_ins_t  core_in;
	logic        sda_out;
	logic        sda_oe_n;
	logic [63:0] d;
	int          fail_count;
	int          n_compared;

	bstap_top #(.ID_VALUE(TB_ID)) u_dut (
		.clk(clk), .nrst(nrst), .tck(tck), .ntrst(ntrst), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_out(core_out), .pin_out(pin_out),
		.pin_in(pin_in), .core_in(core_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n)
	);
	bstap_tester u_tester (
		.tck(tck), .ntrst(ntrst), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic t_functional();
		@(negedge clk);
		core_out = 58'h1A5_C3F0_9E17_B64D;
		pin_in = 4'h6;
		repeat (8) @(negedge clk);
		check(64'(pin_out), 64'(core_out), "pins in functional mode");
		check(64'(core_in), 64'h6, "core inputs in functional mode");
		check(64'(sda_oe_n), 64'h0, "data pin enable");
		$display("test functional done");
	endtask

	task automatic t_ident();
		u_tester.scan(1'b0, 1'b1, 32, 64'h0, d);
		check(d, 64'(TB_ID), "identification");
		$display("test ident done");
	endtask

	// Defined bypass code and undefined codes must all give a one-bit path
	task automatic t_bypass();
		logic [3:0] codes [4];
		codes = '{4'hF, 4'h5, 4'hA, 4'h2};
		foreach (codes[i]) begin
			u_tester.scan(1'b1, 1'b1, 4, 64'(codes[i]), d);
			check(d, 64'h1, "instruction capture");
			u_tester.scan(1'b0, 1'b0, 8, 64'hB4, d);
			check(d, 64'h68, "bypass path");
		end
		$display("test bypass done");
	endtask

	task automatic t_extest();
		@(negedge clk);
		core_out = '0;
		core_out.link_ready_out = 1'b1;
		core_out.counter_bus = 12'h801;
		core_out.data_qualifier[3] = 1'b1;
		pin_in = 4'h8;
		u_tester.scan(1'b1, 1'b1, 4, 64'h0, d);
		u_tester.scan(1'b0, 1'b0, 62, PAT_A, d);
		check(d, 64'h1 | (64'h801 << 25) | (64'h1 << 57) | (64'h1 << 61), "cells");
		repeat (12) @(negedge clk);
		check(64'(pin_out), {6'h0, PAT_A[57:0]}, "pins from update");
		check(64'(sda_oe_n), 64'(PAT_A[1]), "data pin from cell 2");
		core_out = '1;
		repeat (12) @(negedge clk);
		check(64'(pin_out), {6'h0, PAT_A[57:0]}, "pins held");
		check(64'(core_in), 64'h8, "core inputs outside internal test");
		$display("test extest done");
	endtask

	task automatic t_intest();
		// Pins change before the instruction scan; the snapshot only refreshes while tck runs
		@(negedge clk);
		pin_in = 4'h3;
		u_tester.scan(1'b1, 1'b1, 4, 64'h3, d);
		u_tester.scan(1'b0, 1'b0, 62, PAT_B, d);
		check(d, {2'b00, 4'h3, {58{1'b1}}}, "internal capture");
		repeat (12) @(negedge clk);
		check(64'(core_in), 64'(PAT_B[61:58]), "core stimulus");
		check(64'(pin_out), {6'h0, PAT_B[57:0]}, "pins under internal test");
		$display("test intest done");
	endtask

	initial begin
		nrst = 1'b0;
		core_out = '0;
		pin_in = '0;
		fail_count = 0;
		n_compared = 0;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		u_tester.reset_port();
		t_functional();
		t_ident();
		t_bypass();
		t_extest();
		t_intest();
		conclude();
	end

	// Whole run needs well under a millisecond of test clock traffic
	initial begin
		#2000000;
		fail_count++;
		$display("Watchdog expired");
		conclude();
	end
endmodule // boundary_scan_tap_tb_top

`default_nettype wire
